/* cfg_indexed_bank.sv */
// Indexed configuration register bank reached through two host I/O ports
// Summary of operation
// - Host writes: index then data updates register
// - Index low three bits select registers 0-5
// - Register 0 bit 7 selects 1M DRAM
// - Register 0 bits 6-5 set bank population
// - Register 0 shadow enables and 384K relocation
// - Register 1 page mode and mixed DRAM
// - Register 1 RAS precharge 16 down to 2
// - Register 2 bit 5 non-page wait states
// - Register 2 bit 4 page-hit wait states
// - Register 2 CAS precharge and active lengths
// - Page mode off ignores CAS and bit 5
// - Register 3 holds expansion base segment count
// - Register 4 I/O speed, read-only revision nibble
// - Register 4 bit 1 interleave type, page default
// - Register 4 coprocessor select, ROM select disable
// - Register 5 sleep enable and sleep clocks
// - Register 5 bit 3 idle hispeed switch
// - Register 5 parity disable and CAS sharing
`timescale 1ns/1ns
`default_nettype none
module cfg_indexed_bank
  import cfg_bank_pkg::*;
#(
  parameter logic [3:0] REVISION_ID = 4'h5  // Arbitrary value
)(
  input  wire logic              CLK_I,
  input  wire logic              NRST_I,
  input  wire logic [15:0]       IO_ADDR_I,
  input  wire logic [7:0]        IO_WDATA_I,
  input  wire logic              IO_WR_I,
  input  wire logic              IO_RD_I,
  output logic      [7:0]        IO_RDATA_O,
  output logic                   IO_RVALID_O,
  output mem_ctrl_s              MEM_CTRL_O,
  output power_ctrl_s            POWER_CTRL_O
);

  logic [7:0] index_reg;
  logic [7:0] bank_reg;
  logic [7:0] page_reg;
  logic [7:0] wait_reg;
  logic [7:0] expan_reg;
  logic [7:0] iospd_reg;
  logic [7:0] sleep_reg;
  logic [7:0] rdata_reg;
  logic       rvalid_reg;
  logic [7:0] rdata_next;

  logic       idx_hit;
  logic       dat_hit;
  logic       dat_wr;
  logic [2:0] sel;
  logic       sel_valid;

  assign idx_hit   = (IO_ADDR_I == INDEX_PORT_ADDR);
  assign dat_hit   = (IO_ADDR_I == DATA_PORT_ADDR);
  assign dat_wr    = IO_WR_I && dat_hit;
  assign sel       = index_reg[2:0];
  assign sel_valid = (sel <= IDX_SLEEP);

  // Index port keeps all eight bits so software reads back what it wrote
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      index_reg <= RST_INDEX;
    end else if (IO_WR_I && idx_hit) begin
      index_reg <= IO_WDATA_I;
    end
  end

  // Data port writes land in the selected register only
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      bank_reg  <= RST_BANK;
      page_reg  <= RST_PAGE;
      wait_reg  <= RST_WAIT;
      expan_reg <= RST_EXPAN;
      iospd_reg <= RST_IOSPD;
      sleep_reg <= RST_SLEEP;
    end else if (dat_wr && sel_valid) begin
      unique case (sel)
        IDX_BANK:  bank_reg  <= IO_WDATA_I & MASK_BANK;
        IDX_PAGE:  page_reg  <= IO_WDATA_I & MASK_PAGE;
        IDX_WAIT:  wait_reg  <= (IO_WDATA_I & MASK_WAIT) | RST_WAIT;
        IDX_EXPAN: expan_reg <= IO_WDATA_I;
        IDX_IOSPD: iospd_reg <= IO_WDATA_I & MASK_IOSPD;
        IDX_SLEEP: sleep_reg <= IO_WDATA_I & MASK_SLEEP;
        default:   bank_reg  <= bank_reg;
      endcase
    end
  end

  always_comb begin
    rdata_next = 8'h00;
    if (idx_hit) begin
      rdata_next = index_reg;
    end else if (dat_hit) begin
      unique case (sel)
        IDX_BANK:  rdata_next = bank_reg;
        IDX_PAGE:  rdata_next = page_reg;
        IDX_WAIT:  rdata_next = wait_reg;
        IDX_EXPAN: rdata_next = expan_reg;
        IDX_IOSPD: rdata_next = {REVISION_ID, iospd_reg[3:0]};
        IDX_SLEEP: rdata_next = sleep_reg;
        default:   rdata_next = 8'h00;
      endcase
    end
  end

  // Registered read answer, one cycle after the read strobe
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= IO_RD_I && (idx_hit || dat_hit);
      if (IO_RD_I) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  assign IO_RDATA_O  = rdata_reg;
  assign IO_RVALID_O = rvalid_reg;

  logic [2:0] banks_w;
  logic [2:0] ways_w;
  logic [4:0] ras_w;
  logic [1:0] npw_w;
  logic [1:0] phw_w;
  logic [2:0] casp_w;
  logic [2:0] casa_w;

  cfg_bank_decode u_bank (
    .pop_code_i (bank_reg[BANK_POP_LSB +: 2]),
    .banks_o    (banks_w),
    .ways_o     (ways_w)
  );

  cfg_timing_decode u_timing (
    .page_cfg_i (page_reg),
    .wait_cfg_i (wait_reg),
    .ras_pre_o  (ras_w),
    .np_waits_o (npw_w),
    .ph_waits_o (phw_w),
    .cas_pre_o  (casp_w),
    .cas_act_o  (casa_w)
  );

  always_comb begin
    MEM_CTRL_O               = '0;
    MEM_CTRL_O.dram_1m       = bank_reg[BANK_DENS_BIT];
    MEM_CTRL_O.banks_on      = banks_w;
    MEM_CTRL_O.ilv_ways      = ways_w;
    MEM_CTRL_O.shadow_f      = bank_reg[SHADOW_F_BIT];
    MEM_CTRL_O.shadow_e      = bank_reg[SHADOW_E_BIT];
    MEM_CTRL_O.reloc_384k    = bank_reg[RELOC_BIT];
    MEM_CTRL_O.page_mode     = page_reg[PAGE_EN_BIT];
    MEM_CTRL_O.mixed_dram    = page_reg[MIXED_BIT];
    MEM_CTRL_O.ras_pre_clks  = ras_w;
    MEM_CTRL_O.np_waits      = npw_w;
    MEM_CTRL_O.ph_waits      = phw_w;
    MEM_CTRL_O.cas_pre_clks  = casp_w;
    MEM_CTRL_O.cas_act_clks  = casa_w;
    MEM_CTRL_O.exp_base_seg  = expan_reg;
    MEM_CTRL_O.io_full_speed = iospd_reg[IOSPD_BIT];
    MEM_CTRL_O.copro_sel     = iospd_reg[COPRO_BIT];
    MEM_CTRL_O.page_ilv      = iospd_reg[ILV_BIT];
    MEM_CTRL_O.rom_cs_off    = iospd_reg[ROMCS_BIT];
  end

  always_comb begin
    POWER_CTRL_O              = '0;
    POWER_CTRL_O.sleep_en     = sleep_reg[SLEEP_EN_BIT];
    POWER_CTRL_O.sleep_freq   = sleep_reg[SLEEP_FRQ_LSB +: 3];
    POWER_CTRL_O.hispeed_idle = sleep_reg[HISPD_BIT];
    POWER_CTRL_O.parity_off   = sleep_reg[PAR_DIS_BIT];
    POWER_CTRL_O.cas_share    = sleep_reg[CAS_SHR_BIT];
  end

  // Assertions
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);

  // Index port behaviour
  idx_write_a: assert property (
    IO_WR_I && idx_hit |=> index_reg == $past(IO_WDATA_I))
    else $error("index not captured");

  idx_hold_a: assert property (
    !(IO_WR_I && idx_hit) |=> $stable(index_reg))
    else $error("index changed without write");

  idx_read_a: assert property (
    IO_RD_I && idx_hit |=> IO_RDATA_O == $past(index_reg))
    else $error("index read back wrong");

  stray_write_a: assert property (
    IO_WR_I && !idx_hit && !dat_hit |=> $stable(index_reg) && $stable(page_reg) && $stable(wait_reg))
    else $error("foreign address wrote a register");

  // Data port writes
  data_write_a: assert property (
    dat_wr && sel == IDX_EXPAN |=> expan_reg == $past(IO_WDATA_I))
    else $error("data write lost");

  bank_write_a: assert property (
    dat_wr && sel == IDX_BANK |=> bank_reg == ($past(IO_WDATA_I) & MASK_BANK))
    else $error("bank register write lost");

  page_write_a: assert property (
    dat_wr && sel == IDX_PAGE |=> page_reg == ($past(IO_WDATA_I) & MASK_PAGE))
    else $error("page register write lost");

  wait_write_a: assert property (
    dat_wr && sel == IDX_WAIT |=> wait_reg == (($past(IO_WDATA_I) & MASK_WAIT) | RST_WAIT))
    else $error("wait register write lost");

  iospd_write_a: assert property (
    dat_wr && sel == IDX_IOSPD |=> iospd_reg == ($past(IO_WDATA_I) & MASK_IOSPD))
    else $error("speed register write lost");

  sleep_write_a: assert property (
    dat_wr && sel == IDX_SLEEP |=> sleep_reg == ($past(IO_WDATA_I) & MASK_SLEEP))
    else $error("sleep register write lost");

  bad_index_a: assert property (
    dat_wr && !sel_valid |=> $stable(bank_reg) && $stable(sleep_reg))
    else $error("codes 6-7 wrote a register");

  read_only_a: assert property (
    !IO_WR_I |=> $stable(bank_reg) && $stable(expan_reg) && $stable(iospd_reg))
    else $error("register changed without write");

  // Read answer
  read_back_a: assert property (
    IO_RD_I && dat_hit && sel == IDX_PAGE |=> IO_RVALID_O && IO_RDATA_O == $past(page_reg))
    else $error("read data wrong");

  rev_read_a: assert property (
    IO_RD_I && dat_hit && sel == IDX_IOSPD |=> IO_RDATA_O[7:4] == REVISION_ID)
    else $error("revision nibble wrong");

  void_read_a: assert property (
    IO_RD_I && dat_hit && !sel_valid |=> IO_RDATA_O == 8'h00)
    else $error("codes 6-7 returned data");

  rd_hold_a: assert property (
    !IO_RD_I |=> $stable(IO_RDATA_O))
    else $error("read data moved without strobe");

  rvalid_set_a: assert property (
    IO_RD_I && (idx_hit || dat_hit) |=> IO_RVALID_O)
    else $error("read valid missing");

  rvalid_clr_a: assert property (
    !(IO_RD_I && (idx_hit || dat_hit)) |=> !IO_RVALID_O)
    else $error("read valid without read");

  // Reserved bits stay at their fixed values
  wait_fixed_a: assert property (
    wait_reg[7:6] == 2'b11)
    else $error("reserved ones lost");

  bank_zero_a: assert property (
    bank_reg[1:0] == 2'b00)
    else $error("bank reserved bits set");

  page_zero_a: assert property (
    page_reg[2:0] == 3'b000)
    else $error("page reserved bits set");

  sleep_zero_a: assert property (
    sleep_reg[0] == 1'b0)
    else $error("sleep reserved bit set");

  // Decoded controls
  pop_one_a: assert property (
    bank_reg[6:5] == 2'b00 |-> MEM_CTRL_O.banks_on == 3'h1 && MEM_CTRL_O.ilv_ways == 3'h0)
    else $error("one bank decode wrong");

  pop_two_a: assert property (
    bank_reg[6:5] == 2'b01 |-> MEM_CTRL_O.banks_on == 3'h2 && MEM_CTRL_O.ilv_ways == 3'h2)
    else $error("two bank decode wrong");

  pop_three_a: assert property (
    bank_reg[6:5] == 2'b10 |-> MEM_CTRL_O.banks_on == 3'h3 && MEM_CTRL_O.ilv_ways == 3'h0)
    else $error("three bank decode wrong");

  pop_four_a: assert property (
    bank_reg[6:5] == 2'b11 |-> MEM_CTRL_O.banks_on == 3'h4 && MEM_CTRL_O.ilv_ways == 3'h4)
    else $error("bank decode wrong");

  ras_code_a: assert property (
    page_reg[5:3] == 3'b111 |-> MEM_CTRL_O.ras_pre_clks == 5'h02)
    else $error("ras decode wrong");

  ras_long_a: assert property (
    page_reg[5:3] == 3'b000 |-> MEM_CTRL_O.ras_pre_clks == 5'h10)
    else $error("long ras decode wrong");

  np_zero_a: assert property (
    page_reg[PAGE_EN_BIT] && wait_reg[NP_WAIT_BIT] |-> MEM_CTRL_O.np_waits == 2'h0)
    else $error("non-page zero wait wrong");

  np_one_a: assert property (
    !wait_reg[NP_WAIT_BIT] |-> MEM_CTRL_O.np_waits == 2'h1)
    else $error("non-page one wait wrong");

  ph_zero_a: assert property (
    wait_reg[PH_WAIT_BIT] |-> MEM_CTRL_O.ph_waits == 2'h0)
    else $error("page hit zero wait wrong");

  ph_one_a: assert property (
    !wait_reg[PH_WAIT_BIT] |-> MEM_CTRL_O.ph_waits == 2'h1)
    else $error("page hit one wait wrong");

  cas_pre_a: assert property (
    page_reg[PAGE_EN_BIT] && wait_reg[3:2] == 2'b01 |-> MEM_CTRL_O.cas_pre_clks == 3'h2)
    else $error("cas precharge decode wrong");

  cas_act_a: assert property (
    page_reg[PAGE_EN_BIT] && wait_reg[1:0] == 2'b11 |-> MEM_CTRL_O.cas_act_clks == 3'h1)
    else $error("cas active decode wrong");

  np_ignore_a: assert property (
    !page_reg[PAGE_EN_BIT] |-> MEM_CTRL_O.np_waits == 2'h1 && MEM_CTRL_O.cas_act_clks == 3'h4)
    else $error("fields not ignored");

  cas_idle_a: assert property (
    !page_reg[PAGE_EN_BIT] |-> MEM_CTRL_O.cas_pre_clks == 3'h3)
    else $error("precharge not ignored");

  write_read_c: cover property (dat_wr ##1 IO_RD_I && dat_hit);
  sleep_on_c: cover property (POWER_CTRL_O.sleep_en);
  page_mode_c: cover property (MEM_CTRL_O.page_mode && wait_reg[5]);
  bad_index_c: cover property (dat_wr && !sel_valid);
  rev_read_c: cover property (IO_RD_I && dat_hit && sel == IDX_IOSPD);

endmodule : cfg_indexed_bank
`default_nettype wire

/* cfg_bank_pkg.sv */
// Shared constants and types for the indexed configuration bank
package cfg_bank_pkg;

  localparam logic [15:0] INDEX_PORT_ADDR = 16'h01ED;
  localparam logic [15:0] DATA_PORT_ADDR  = 16'h01EF;

  localparam logic [2:0] IDX_BANK   = 3'h0;
  localparam logic [2:0] IDX_PAGE   = 3'h1;
  localparam logic [2:0] IDX_WAIT   = 3'h2;
  localparam logic [2:0] IDX_EXPAN  = 3'h3;
  localparam logic [2:0] IDX_IOSPD  = 3'h4;
  localparam logic [2:0] IDX_SLEEP  = 3'h5;

  localparam logic [7:0] RST_INDEX  = 8'h00;
  localparam logic [7:0] RST_BANK   = 8'h00;
  localparam logic [7:0] RST_PAGE   = 8'h00;
  localparam logic [7:0] RST_WAIT   = 8'hC0;
  localparam logic [7:0] RST_EXPAN  = 8'h00;
  localparam logic [7:0] RST_IOSPD  = 8'h02;
  localparam logic [7:0] RST_SLEEP  = 8'h00;

  // Writable masks: reserved bits are held at their fixed values
  localparam logic [7:0] MASK_BANK  = 8'hFC;
  localparam logic [7:0] MASK_PAGE  = 8'hF8;
  localparam logic [7:0] MASK_WAIT  = 8'h3F;
  localparam logic [7:0] MASK_IOSPD = 8'h0F;
  localparam logic [7:0] MASK_SLEEP = 8'hFE;

  localparam int BANK_DENS_BIT = 7;
  localparam int BANK_POP_LSB  = 5;
  localparam int SHADOW_F_BIT  = 4;
  localparam int SHADOW_E_BIT  = 3;
  localparam int RELOC_BIT     = 2;
  localparam int PAGE_EN_BIT   = 7;
  localparam int MIXED_BIT     = 6;
  localparam int RAS_LSB       = 3;
  localparam int NP_WAIT_BIT   = 5;
  localparam int PH_WAIT_BIT   = 4;
  localparam int CASP_LSB      = 2;
  localparam int CASA_LSB      = 0;
  localparam int IOSPD_BIT     = 3;
  localparam int COPRO_BIT     = 2;
  localparam int ILV_BIT       = 1;
  localparam int ROMCS_BIT     = 0;
  localparam int SLEEP_EN_BIT  = 7;
  localparam int SLEEP_FRQ_LSB = 4;
  localparam int HISPD_BIT     = 3;
  localparam int PAR_DIS_BIT   = 2;
  localparam int CAS_SHR_BIT   = 1;

  typedef struct packed {
    logic       dram_1m;
    logic [2:0] banks_on;
    logic [2:0] ilv_ways;
    logic       shadow_f;
    logic       shadow_e;
    logic       reloc_384k;
    logic       page_mode;
    logic       mixed_dram;
    logic [4:0] ras_pre_clks;
    logic [1:0] np_waits;
    logic [1:0] ph_waits;
    logic [2:0] cas_pre_clks;
    logic [2:0] cas_act_clks;
    logic [7:0] exp_base_seg;
    logic       io_full_speed;
    logic       copro_sel;
    logic       page_ilv;
    logic       rom_cs_off;
  } mem_ctrl_s;

  typedef struct packed {
    logic       sleep_en;
    logic [2:0] sleep_freq;
    logic       hispeed_idle;
    logic       parity_off;
    logic       cas_share;
  } power_ctrl_s;

endpackage : cfg_bank_pkg

/* cfg_timing_decode.sv */
// Timing field decoder for memory page mode and CAS cycles
`timescale 1ns/1ns
`default_nettype none
module cfg_timing_decode
  import cfg_bank_pkg::*;
(
  input  wire logic [7:0] page_cfg_i,
  input  wire logic [7:0] wait_cfg_i,
  output logic      [4:0] ras_pre_o,
  output logic      [1:0] np_waits_o,
  output logic      [1:0] ph_waits_o,
  output logic      [2:0] cas_pre_o,
  output logic      [2:0] cas_act_o
);
  logic       page_on;
  logic [2:0] ras_code;
  logic [1:0] casp_code;
  logic [1:0] casa_code;

  assign page_on   = page_cfg_i[PAGE_EN_BIT];
  assign ras_code  = page_cfg_i[RAS_LSB +: 3];
  assign casp_code = wait_cfg_i[CASP_LSB +: 2];
  assign casa_code = wait_cfg_i[CASA_LSB +: 2];

  // 16 down to 2 in steps of two
  assign ras_pre_o = 5'h10 - {1'b0, ras_code, 1'b0};

  // Without page mode the non-page wait and CAS fields are don't-care; report defaults
  assign np_waits_o = (page_on && wait_cfg_i[NP_WAIT_BIT]) ? 2'h0 : 2'h1;
  assign ph_waits_o = wait_cfg_i[PH_WAIT_BIT] ? 2'h0 : 2'h1;

  // Code 10 is undocumented for precharge and treated like 11
  always_comb begin
    cas_pre_o = 3'h3;
    cas_act_o = 3'h4;
    if (page_on) begin
      unique case (casp_code)
        2'b00: cas_pre_o = 3'h3;
        2'b01: cas_pre_o = 3'h2;
        2'b10: cas_pre_o = 3'h1;
        2'b11: cas_pre_o = 3'h1;
      endcase
      cas_act_o = 3'h4 - {1'b0, casa_code};
    end
  end
endmodule : cfg_timing_decode
`default_nettype wire

/* cfg_bank_decode.sv */
// Bank population decoder for bank count and interleave ways
`timescale 1ns/1ns
`default_nettype none
module cfg_bank_decode
  import cfg_bank_pkg::*;
(
  input  wire logic [1:0] pop_code_i,
  output logic      [2:0] banks_o,
  output logic      [2:0] ways_o
);
  always_comb begin
    banks_o = 3'h1;
    ways_o  = 3'h0;
    unique case (pop_code_i)
      2'b00: begin
        banks_o = 3'h1;
        ways_o  = 3'h0;
      end
      2'b01: begin
        banks_o = 3'h2;
        ways_o  = 3'h2;
      end
      2'b10: begin
        banks_o = 3'h3;
        ways_o  = 3'h0;
      end
      2'b11: begin
        banks_o = 3'h4;
        ways_o  = 3'h4;
      end
    endcase
  end
endmodule : cfg_bank_decode
`default_nettype wire

/* dram_bank_model.sv */
// Behavioural model of the DRAM banks that consume the timing fields
`timescale 1ns/1ns
`default_nettype none
module dram_bank_model
  import cfg_bank_pkg::*;
(
  input  wire mem_ctrl_s  mem_i,
  output logic      [3:0] cas_sum_o,
  output logic            timing_ok_o
);
  // A page hit lasts CAS active plus precharge; a sum above 4 (zero page-hit waits) or 6 corrupts data
  always_comb begin
    cas_sum_o   = {1'b0, mem_i.cas_pre_clks} + {1'b0, mem_i.cas_act_clks};
    timing_ok_o = !mem_i.page_mode ||
                  (cas_sum_o <= ((mem_i.ph_waits == 2'h0) ? 4'h4 : 4'h6));
  end
endmodule : dram_bank_model
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the indexed configuration bank
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import cfg_bank_pkg::*;
;
  typedef struct packed {logic [7:0] idx; logic [7:0] wr; logic [7:0] rd;} row_s;
  localparam logic [3:0] REV = 4'h5;  // Arbitrary value
  logic        clk, nrst, io_wr, io_rd, rvalid, t_ok, v;
  logic [15:0] io_addr;
  logic [7:0]  io_wdata, rdata, d;
  logic [3:0]  cas_sum;
  mem_ctrl_s   mem;
  power_ctrl_s pwr;
  int          miscompares, n_checks, cycles;
  row_s        rows [8];

  cfg_indexed_bank #(.REVISION_ID(REV)) i_cfg_indexed_bank (
    .CLK_I(clk), .NRST_I(nrst), .IO_ADDR_I(io_addr), .IO_WDATA_I(io_wdata),
    .IO_WR_I(io_wr), .IO_RD_I(io_rd), .IO_RDATA_O(rdata), .IO_RVALID_O(rvalid),
    .MEM_CTRL_O(mem), .POWER_CTRL_O(pwr));
  dram_bank_model i_dram_bank_model (.mem_i(mem), .cas_sum_o(cas_sum), .timing_ok_o(t_ok));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic give_verdict();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One-cycle strobe, then a settle step so register updates have landed
  task automatic io_write(input logic [15:0] a, input logic [7:0] dat);
    @(posedge clk);
    io_addr  <= a;
    io_wdata <= dat;
    io_wr    <= 1'b1;
    @(posedge clk);
    io_wr <= 1'b0;
    #1;
  endtask : io_write

  task automatic io_read(input logic [15:0] a);
    @(posedge clk);
    io_addr <= a;
    io_rd   <= 1'b1;
    @(posedge clk);
    io_rd <= 1'b0;
    #1;
    v = rvalid;
    d = rdata;
  endtask : io_read

  task automatic reg_wr(input logic [7:0] i, input logic [7:0] dat);
    io_write(INDEX_PORT_ADDR, i);
    io_write(DATA_PORT_ADDR, dat);
  endtask : reg_wr

  task automatic rd_reg(input logic [7:0] i, input logic [7:0] exp);
    io_write(INDEX_PORT_ADDR, i);
    io_read(DATA_PORT_ADDR);
    chk(8'(v), 8'h01);
    chk(d, exp);
  endtask : rd_reg

  initial begin
    nrst = 1'b0; io_wr = 1'b0; io_rd = 1'b0; io_addr = 16'h0000; io_wdata = 8'h00;
    miscompares = 0; n_checks = 0; cycles = 0;
    rows = '{'{8'h00, 8'hFF, 8'hFC}, '{8'h01, 8'hFF, 8'hF8}, '{8'h02, 8'h00, 8'hC0},
             '{8'h03, 8'hA5, 8'hA5}, '{8'h04, 8'hFF, {REV, 4'hF}}, '{8'h05, 8'hFF, 8'hFE},
             '{8'h06, 8'hFF, 8'h00}, '{8'h07, 8'h3C, 8'h00}};
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rd_reg(8'h00, RST_BANK);
    rd_reg(8'h02, 8'hC0);
    rd_reg(8'h04, {REV, 4'h2});
    chk(8'(mem.page_ilv), 8'h01);
    $display("test reset values done");
    for (int r = 0; r < 8; r++) begin
      reg_wr(rows[r].idx, rows[r].wr);
      rd_reg(rows[r].idx, rows[r].rd);
    end
    chk(mem.exp_base_seg, 8'hA5);
    $display("test register table done");
    // Upper index bits are reserved, yet read back as written
    io_write(INDEX_PORT_ADDR, 8'hFB);
    io_read(INDEX_PORT_ADDR);
    chk(d, 8'hFB);
    io_read(DATA_PORT_ADDR);
    chk(d, 8'hA5);
    io_read(DATA_PORT_ADDR);
    chk(d, 8'hA5);
    io_write(16'h01EE, 8'h11);
    io_read(16'h01EE);
    chk(8'(v), 8'h00);
    io_read(DATA_PORT_ADDR);
    chk(d, 8'hA5);
    $display("test index and decode done");
    for (int c = 0; c < 8; c++) begin
      reg_wr(8'h01, {2'b10, c[2:0], 3'b000});
      chk(8'(mem.ras_pre_clks), 8'(16 - 2 * c));
      chk(8'(mem.page_mode), 8'h01);
    end
    reg_wr(8'h01, 8'hC0);
    chk(8'(mem.mixed_dram), 8'h01);
    // Timing pairs chosen to stay inside the CAS sum limit
    for (int k = 0; k < 4; k++) begin
      reg_wr(8'h02, {2'b11, k[1], 1'(k != 3), k[1:0], 2'(3 - k)});
      chk(8'(mem.np_waits), k[1] ? 8'h00 : 8'h01);
      chk(8'(mem.ph_waits), (k != 3) ? 8'h00 : 8'h01);
      chk(8'(mem.cas_pre_clks), (k == 0) ? 8'h03 : (k == 1) ? 8'h02 : 8'h01);
      chk(8'(mem.cas_act_clks), 8'(k + 1));
      chk(8'(t_ok), 8'h01);
    end
    reg_wr(8'h01, 8'h00);
    chk({mem.np_waits, mem.cas_pre_clks, mem.cas_act_clks}, 8'h5C);
    $display("test memory timing done");
    for (int c = 0; c < 4; c++) begin
      reg_wr(8'h00, {c[0], c[1:0], c[1], c[0], c[1], 2'b00});
      chk({mem.dram_1m, mem.shadow_f, mem.shadow_e, mem.reloc_384k},
          {4'h0, c[0], c[1], c[0], c[1]});
      chk(8'(mem.banks_on), 8'(c + 1));
      chk(8'(mem.ilv_ways), (c == 1) ? 8'h02 : (c == 3) ? 8'h04 : 8'h00);
    end
    reg_wr(8'h04, 8'h0D);
    chk({mem.io_full_speed, mem.copro_sel, mem.page_ilv, mem.rom_cs_off}, 8'h0D);
    reg_wr(8'h04, 8'h02);
    chk({mem.io_full_speed, mem.copro_sel, mem.page_ilv, mem.rom_cs_off}, 8'h02);
    for (int c = 0; c < 5; c++) begin
      reg_wr(8'h05, {1'b1, c[2:0], c[0], c[0], c[0], 1'b1});
      chk(8'(pwr), {1'b0, 1'b1, c[2:0], c[0], c[0], c[0]});
    end
    $display("test bank and power done");
    reg_wr(8'h01, 8'h80);
    @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    rd_reg(8'h03, RST_EXPAN);
    rd_reg(8'h01, RST_PAGE);
    $display("test second reset done");
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
